// file: verilog/ptmr_map.vh
// Purpose: Register indices, field positions and reset values of the timer
// Assumes: Byte address of a register is four times its index
// Notes: Data is 8 bits wide in the low byte of the APB word
`ifndef PTMR_MAP_VH
`define PTMR_MAP_VH
// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define PTMR_IDX_MODE 8'h50
`define PTMR_IDX_PRE 8'h51
`define PTMR_IDX_TMR 8'h52
`define PTMR_IDX_CSS 8'h53
`define PTMR_IDX_STAT 8'h54
`define PTMR_IDX_MASK 8'h55
`define PTMR_IDX_TIC 8'h56
// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define PTMR_MR_RUN 3
`define PTMR_MR_EDG 5
`define PTMR_MR_UND 6
`define PTMR_MR_POL 7
`define PTMR_MODE_TIMER 2'h0
`define PTMR_MODE_PULSE 2'h1
`define PTMR_MODE_EVENT 2'h2
`define PTMR_MODE_PERIOD 2'h3
// ----------------------------------------------------------------
// Count source select and interrupt control fields
// ----------------------------------------------------------------
`define PTMR_CSS_DIV1 2'h0
`define PTMR_CSS_DIV8 2'h1
`define PTMR_CSS_DIV32 2'h2
`define PTMR_CSS_EXT 2'h3
`define PTMR_TIC_REQ 3
// ----------------------------------------------------------------
// Status bits and reset values
// ----------------------------------------------------------------
`define PTMR_ST_TUF 0
`define PTMR_ST_EDG 1
`define PTMR_ST_PUF 2
`define PTMR_PRE_RST 8'hFF
`define PTMR_TMR_RST 8'hFF
`endif

// file: verilog/ptmr_sync.v
// Purpose: Three-stage synchroniser with edge pulses for the pin input
// Assumes: Input comes from outside the ref_clk domain
// Notes: A change counts once the second and third stages agree
`timescale 1ns/1ps
module ptmr_sync
(
    input wire ref_clk,
    input wire sys_rst,
    input wire pin_in,
    output reg level,
    output reg rise,
    output reg fall
);
reg s1;
reg s2;
reg s3;
// ----------------------------------------------------------------
// Synchroniser chain and filtered level
// ----------------------------------------------------------------
// Only s2 reads s1; level moves when s2 and s3 agree
always @(posedge ref_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        level <= 1'b0;
        rise <= 1'b0;
        fall <= 1'b0;
    end
    else
    begin
        s1 <= pin_in;
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3)
            level <= s3;
        rise <= (s2 == s3) && s3 && !level;
        fall <= (s2 == s3) && !s3 && level;
    end
end
endmodule // ptmr_sync

// file: verilog/ptmr_top.v
// Purpose: Eight-bit prescaler and timer with modes, APB registers, interrupt
// Assumes: APB slave, byte data in bits 7:0, one clock ref_clk
// Notes: Contract
// Contract
// - Timer stopped after reset; load before start
// - Byte reads separate; counter may advance between
// - Period mode: write 0 clears flags, 1 keeps
// - Flags undefined entering period mode; software clears
// - Prescaler underflow after start may set edge
// - Run reads 0 until next count source edge
// - Stop takes effect at next count source edge
// - Mode change sets request flag; software clears
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "ptmr_map.vh"
module ptmr_top #(parameter AW = 12)
(
    input wire ref_clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [AW-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire meas_pin,
    input wire irq_ack,
    output reg pulse_out,
    output reg req_out,
    output reg irq
);
// ----------------------------------------------------------------
// State
// ----------------------------------------------------------------
reg [1:0] op_mode;
reg op_extra;
reg pol;
reg run_req;
reg run_state;
reg edge_f;
reg und_f;
reg [7:0] pre_rld;
reg [7:0] pre_cnt;
reg [7:0] tmr_rld;
reg [7:0] tmr_cnt;
reg [1:0] css;
reg [2:0] stat;
reg [2:0] mask;
reg [2:0] tic_lvl;
reg req_flag;
reg first_pre;
reg [4:0] div_cnt;
reg src_tick;
reg [7:0] rd_mux;
reg rd_ok;
wire pin_level;
wire pin_rise;
wire pin_fall;
// ----------------------------------------------------------------
// Pin synchroniser
// ----------------------------------------------------------------
ptmr_sync u_sync
(
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in(meas_pin),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
);
// ----------------------------------------------------------------
// Bus decode
// ----------------------------------------------------------------
// Word index of the access; upper bits must be zero to hit
wire [7:0] idx = paddr[9:2];
wire upper_ok = (paddr[AW-1:10] == {(AW-10){1'b0}}) && (paddr[1:0] == 2'h0);
wire acc = psel && penable && pready;
wire wr = acc && pwrite && pstrb[0] && !pslverr;
wire [7:0] wd = pwdata[7:0];
wire wr_mode = wr && (idx == `PTMR_IDX_MODE);
wire wr_pre = wr && (idx == `PTMR_IDX_PRE);
wire wr_tmr = wr && (idx == `PTMR_IDX_TMR);
wire wr_css = wr && (idx == `PTMR_IDX_CSS);
wire wr_stat = wr && (idx == `PTMR_IDX_STAT);
wire wr_mask = wr && (idx == `PTMR_IDX_MASK);
wire wr_tic = wr && (idx == `PTMR_IDX_TIC);
// ----------------------------------------------------------------
// Count source
// ----------------------------------------------------------------
wire period = (op_mode == `PTMR_MODE_PERIOD) && op_extra;
wire act_edge = pol ? pin_fall : pin_rise;
// Selected count source as a one-cycle pulse; event mode counts the pin
always @*
begin
    src_tick = 1'b1;
    if (op_mode == `PTMR_MODE_EVENT)
        src_tick = act_edge;
    else
    begin
        case (css)
            `PTMR_CSS_DIV1: src_tick = 1'b1;
            `PTMR_CSS_DIV8: src_tick = (div_cnt[2:0] == 3'h7);
            `PTMR_CSS_DIV32: src_tick = (div_cnt == 5'h1F);
            `PTMR_CSS_EXT: src_tick = act_edge;
            default: src_tick = 1'b0;
        endcase
    end
end
// Counting uses the requested run bit at each source edge
wire cnt_en = src_tick && run_req;
wire pre_uf = cnt_en && (pre_cnt == 8'h00);
wire tmr_uf = pre_uf && (tmr_cnt == 8'h00);
wire meas_edge = period && run_state && act_edge;
wire edge_set = meas_edge || (period && pre_uf && first_pre);
wire und_set = period && tmr_uf;
wire mode_chg = wr_mode && (wd[2:0] != {op_extra, op_mode});
wire [2:0] ev = {pre_uf, edge_set, tmr_uf};
// ----------------------------------------------------------------
// Free-running divider
// ----------------------------------------------------------------
always @(posedge ref_clk or posedge sys_rst)
begin
    if (sys_rst)
        div_cnt <= 5'h00;
    else
        div_cnt <= div_cnt + 5'h01;
end
// ----------------------------------------------------------------
// Mode register and run control
// ----------------------------------------------------------------
// Run state follows the request only at a count source edge
always @(posedge ref_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        op_mode <= `PTMR_MODE_TIMER;
        op_extra <= 1'b0;
        pol <= 1'b0;
        run_req <= 1'b0;
        run_state <= 1'b0;
        first_pre <= 1'b0;
    end
    else
    begin
        if (wr_mode)
        begin
            op_mode <= wd[1:0];
            op_extra <= wd[2];
            pol <= wd[`PTMR_MR_POL];
            run_req <= wd[`PTMR_MR_RUN];
        end
        if (src_tick)
            run_state <= run_req;
        if (src_tick && run_req && !run_state)
            first_pre <= 1'b1;
        else if (pre_uf)
            first_pre <= 1'b0;
    end
end
// ----------------------------------------------------------------
// Edge and underflow flags
// ----------------------------------------------------------------
// Set wins; in period mode a written 0 clears and a 1 keeps
always @(posedge ref_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        edge_f <= 1'b0;
        und_f <= 1'b0;
    end
    else
    begin
        if (edge_set)
            edge_f <= 1'b1;
        else if (wr_mode && period && !wd[`PTMR_MR_EDG])
            edge_f <= 1'b0;
        if (und_set)
            und_f <= 1'b1;
        else if (wr_mode && period && !wd[`PTMR_MR_UND])
            und_f <= 1'b0;
    end
end
// ----------------------------------------------------------------
// Prescaler and timer counters
// ----------------------------------------------------------------
// Writes load reload value and counter; a measured edge restarts both
always @(posedge ref_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        pre_rld <= `PTMR_PRE_RST;
        pre_cnt <= `PTMR_PRE_RST;
        tmr_rld <= `PTMR_TMR_RST;
        tmr_cnt <= `PTMR_TMR_RST;
        css <= `PTMR_CSS_DIV1;
    end
    else
    begin
        if (wr_css)
            css <= wd[1:0];
        if (wr_pre)
        begin
            pre_rld <= wd;
            pre_cnt <= wd;
        end
        else if (meas_edge || pre_uf)
            pre_cnt <= pre_rld;
        else if (cnt_en)
            pre_cnt <= pre_cnt - 8'h01;
        if (wr_tmr)
        begin
            tmr_rld <= wd;
            tmr_cnt <= wd;
        end
        else if (meas_edge || tmr_uf)
            tmr_cnt <= tmr_rld;
        else if (pre_uf)
            tmr_cnt <= tmr_cnt - 8'h01;
    end
end
// ----------------------------------------------------------------
// Interrupt status, mask and request flag
// ----------------------------------------------------------------
// Sticky status cleared by writing 1; events win over clears
always @(posedge ref_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        stat <= 3'h0;
        mask <= 3'h0;
        tic_lvl <= 3'h0;
        req_flag <= 1'b0;
    end
    else
    begin
        stat <= ev | (stat & ~(wr_stat ? wd[2:0] : 3'h0));
        if (wr_mask)
            mask <= wd[2:0];
        if (wr_tic)
            tic_lvl <= wd[2:0];
        if (tmr_uf || edge_set || mode_chg)
            req_flag <= 1'b1;
        else if (irq_ack || (wr_tic && !wd[`PTMR_TIC_REQ]))
            req_flag <= 1'b0;
    end
end
// ----------------------------------------------------------------
// Registered outputs
// ----------------------------------------------------------------
// Pulse output toggles on timer underflow in pulse mode only
always @(posedge ref_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        pulse_out <= 1'b0;
        req_out <= 1'b0;
        irq <= 1'b0;
    end
    else
    begin
        if (op_mode != `PTMR_MODE_PULSE)
            pulse_out <= 1'b0;
        else if (tmr_uf)
            pulse_out <= !pulse_out;
        req_out <= req_flag && (tic_lvl != 3'h0);
        irq <= |(stat & mask);
    end
end
// ----------------------------------------------------------------
// Read multiplexer
// ----------------------------------------------------------------
// Each register is read alone; no snapshot of the pair
always @*
begin
    rd_mux = 8'h00;
    rd_ok = upper_ok;
    case (idx)
        `PTMR_IDX_MODE: rd_mux = {pol, und_f, edge_f, 1'b0, run_state, op_extra, op_mode};
        `PTMR_IDX_PRE: rd_mux = pre_cnt;
        `PTMR_IDX_TMR: rd_mux = tmr_cnt;
        `PTMR_IDX_CSS: rd_mux = {6'h00, css};
        `PTMR_IDX_STAT: rd_mux = {5'h00, stat};
        `PTMR_IDX_MASK: rd_mux = {5'h00, mask};
        `PTMR_IDX_TIC: rd_mux = {4'h0, req_flag, tic_lvl};
        default: rd_ok = 1'b0;
    endcase
end
// ----------------------------------------------------------------
// APB answer
// ----------------------------------------------------------------
// Setup cycle prepares data and ready; access completes with no wait
always @(posedge ref_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end
    else
    begin
        pready <= psel && !penable;
        if (psel && !penable)
        begin
            pslverr <= !rd_ok;
            prdata <= (rd_ok && !pwrite) ? {24'h000000, rd_mux} : 32'h00000000;
        end
        else
            pslverr <= 1'b0;
    end
end
endmodule // ptmr_top

// file: sim/ptmr_chk_asserts.sv
// Purpose: Port checks on the timer block
// Assumes: One clock, async active-high reset
// Notes: Bound to ptmr_top below
`timescale 1ns/1ps
module ptmr_chk #(parameter AW = 12)
(
    input wire ref_clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [AW-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire meas_pin,
    input wire irq_ack,
    input wire pulse_out,
    input wire req_out,
    input wire irq
);
    // ----
    // Helper state
    // ----
    reg wr_seen;
    // Set by the first write after reset
    always @(posedge ref_clk or posedge sys_rst)
        if (sys_rst)
            wr_seen <= 1'h0;
        else if (psel && pwrite)
            wr_seen <= 1'h1;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Zero wait states, one cycle answer
    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no answer");
    property p_once; pready |=> !pready; endproperty
    a_once: assert property (p_once) else $error("answer too long");
    property p_mis; psel && !penable && paddr[1:0] != 2'h0 |=> pslverr; endproperty
    a_mis: assert property (p_mis) else $error("misaligned accepted");
    property p_map; psel && !penable && paddr == 12'h140 |=> !pslverr; endproperty
    a_map: assert property (p_map) else $error("mode refused");
    property p_byte; prdata[31:8] == 24'h0; endproperty
    a_byte: assert property (p_byte) else $error("upper bytes set");
    property p_hold; pready |=> $stable(prdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_quiet; !wr_seen |-> !irq && !req_out && !pulse_out; endproperty
    a_quiet: assert property (p_quiet) else $error("output after reset");
    property p_err0; pslverr && !pwrite |-> prdata == 32'h0; endproperty
    a_err0: assert property (p_err0) else $error("refused read data");
endmodule // ptmr_chk

bind ptmr_top ptmr_chk #(.AW(AW)) i_ptmr_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_pin(meas_pin), .irq_ack(irq_ack), .pulse_out(pulse_out),
    .req_out(req_out), .irq(irq));

// file: sim/testbench.sv
// Purpose: Register level tests of the timer block
// Assumes: Zero wait APB slave, byte data
// Notes: Pin is the count source in the start and stop test
`timescale 1ns/1ps
`include "ptmr_map.vh"
module testbench;
    reg ref_clk = 1'h0;
    reg sys_rst = 1'h1;
    reg psel = 1'h0;
    reg penable = 1'h0;
    reg pwrite = 1'h0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg [3:0] pstrb = 4'hF;
    reg meas_pin = 1'h0;
    reg irq_ack = 1'h0;
    wire [31:0] prdata;
    wire pready, pslverr, pulse_out, req_out, irq;
    integer n_mismatch = 0;
    integer total_checks = 0;
    integer cyc = 0;
    reg [31:0] rd;
    reg er;
    reg [1:0] alo = 2'h0;
    reg pl;
    ptmr_top #(.AW(12)) i_ptmr_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas_pin(meas_pin),
        .irq_ack(irq_ack), .pulse_out(pulse_out), .req_out(req_out), .irq(irq));
    // ----
    // Clock, timeout and report
    // ----
    initial forever #5 ref_clk = ~ref_clk;
    // Cut a hang short
    always @(posedge ref_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 5000)
        begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: timeout", $time);
            close_out;
        end
    end
    task close_out;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_mismatch);
            if (n_mismatch == 0 && total_checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    task chk(input reg [7:0] got, input reg [7:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp)
            begin
                n_mismatch = n_mismatch + 1;
                $display("wrong value at %0t: got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // One APB transfer, held until pready, then one idle cycle
    task xfer(input reg w, input reg [7:0] idx, input reg [7:0] d);
        begin
            psel <= 1'h1;
            pwrite <= w;
            paddr <= {2'h0, idx, alo};
            pwdata <= {24'h0, d};
            @(posedge ref_clk);
            penable <= 1'h1;
            @(posedge ref_clk);
            while (pready !== 1'h1)
                @(posedge ref_clk);
            rd = prdata;
            er = pslverr;
            psel <= 1'h0;
            penable <= 1'h0;
            @(posedge ref_clk);
        end
    endtask
    task wr(input reg [7:0] idx, input reg [7:0] d);
        xfer(1'h1, idx, d);
    endtask
    task rdc(input reg [7:0] idx, input reg [7:0] m, input reg [7:0] e);
        begin
            xfer(1'h0, idx, 8'h00);
            chk(rd[7:0] & m, e);
        end
    endtask
    // Reads until the masked value shows, at most 41 times
    task poll(input reg [7:0] idx, input reg [7:0] m, input reg [7:0] e);
        integer i;
        begin
            xfer(1'h0, idx, 8'h00);
            for (i = 0; i < 40 && (rd[7:0] & m) !== e; i = i + 1)
                xfer(1'h0, idx, 8'h00);
            chk(rd[7:0] & m, e);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge ref_clk);
    endtask
    // One low then high pulse on the pin, long enough for the synchroniser
    task pin_edge;
        begin
            meas_pin <= 1'h0;
            tick(8);
            meas_pin <= 1'h1;
            tick(8);
        end
    endtask
    // ----
    // Main sequence
    // ----
    initial
    begin
        tick(12);
        sys_rst <= 1'h0;
        tick(1);
        rdc(`PTMR_IDX_MODE, 8'hFF, 8'h00);
        rdc(`PTMR_IDX_PRE, 8'hFF, `PTMR_PRE_RST);
        rdc(`PTMR_IDX_TMR, 8'hFF, `PTMR_TMR_RST);
        rdc(`PTMR_IDX_CSS, 8'hFF, 8'h00);
        rdc(`PTMR_IDX_STAT, 8'hFF, 8'h00);
        rdc(`PTMR_IDX_MASK, 8'hFF, 8'h00);
        rdc(`PTMR_IDX_TIC, 8'hFF, 8'h00);
        xfer(1'h0, 8'h00, 8'h00);
        chk({7'h0, er}, 8'h01);
        // Misaligned access to a mapped register is refused
        alo = 2'h2;
        xfer(1'h0, `PTMR_IDX_MODE, 8'h00);
        alo = 2'h0;
        chk({7'h0, er}, 8'h01);
        pstrb <= 4'h0;
        wr(`PTMR_IDX_PRE, 8'h12);
        pstrb <= 4'hF;
        rdc(`PTMR_IDX_PRE, 8'hFF, 8'hFF);
        // Start and stop follow the pin count source
        wr(`PTMR_IDX_CSS, {6'h0, `PTMR_CSS_EXT});
        wr(`PTMR_IDX_MODE, 8'h08);
        tick(8);
        rdc(`PTMR_IDX_MODE, 8'h08, 8'h00);
        meas_pin <= 1'h1;
        tick(8);
        rdc(`PTMR_IDX_MODE, 8'h08, 8'h08);
        wr(`PTMR_IDX_MODE, 8'h00);
        tick(8);
        rdc(`PTMR_IDX_MODE, 8'h08, 8'h08);
        pin_edge;
        rdc(`PTMR_IDX_MODE, 8'h08, 8'h00);
        // Underflow raises status, irq and request
        wr(`PTMR_IDX_CSS, {6'h0, `PTMR_CSS_DIV1});
        wr(`PTMR_IDX_PRE, 8'h01);
        wr(`PTMR_IDX_TMR, 8'h01);
        wr(`PTMR_IDX_MASK, 8'h01);
        wr(`PTMR_IDX_TIC, 8'h01);
        wr(`PTMR_IDX_MODE, 8'h08);
        poll(`PTMR_IDX_MODE, 8'h08, 8'h08);
        poll(`PTMR_IDX_STAT, 8'h01, 8'h01);
        wr(`PTMR_IDX_MODE, 8'h00);
        poll(`PTMR_IDX_MODE, 8'h08, 8'h00);
        chk({7'h0, irq}, 8'h01);
        chk({7'h0, req_out}, 8'h01);
        rdc(`PTMR_IDX_TIC, 8'h08, 8'h08);
        wr(`PTMR_IDX_MASK, 8'h00);
        tick(1);
        chk({7'h0, irq}, 8'h00);
        wr(`PTMR_IDX_MASK, 8'h01);
        tick(1);
        chk({7'h0, irq}, 8'h01);
        wr(`PTMR_IDX_STAT, 8'h01);
        tick(1);
        chk({7'h0, irq}, 8'h00);
        wr(`PTMR_IDX_TIC, 8'h01);
        tick(1);
        chk({7'h0, req_out}, 8'h00);
        // Mode change requests, acknowledge clears
        wr(`PTMR_IDX_MODE, 8'h01);
        rdc(`PTMR_IDX_TIC, 8'h08, 8'h08);
        irq_ack <= 1'h1;
        tick(1);
        irq_ack <= 1'h0;
        tick(1);
        rdc(`PTMR_IDX_TIC, 8'h08, 8'h00);
        // Pulse output toggles once per four-cycle timer underflow
        wr(`PTMR_IDX_PRE, 8'h00);
        wr(`PTMR_IDX_TMR, 8'h03);
        wr(`PTMR_IDX_MODE, 8'h09);
        poll(`PTMR_IDX_MODE, 8'h08, 8'h08);
        pl = pulse_out;
        tick(4);
        chk({7'h0, pulse_out}, {7'h0, ~pl});
        wr(`PTMR_IDX_MODE, 8'h01);
        poll(`PTMR_IDX_MODE, 8'h08, 8'h00);
        // Period mode flags
        wr(`PTMR_IDX_PRE, 8'hFF);
        wr(`PTMR_IDX_TMR, 8'hFF);
        wr(`PTMR_IDX_TIC, 8'h00);
        wr(`PTMR_IDX_MODE, 8'h03);
        rdc(`PTMR_IDX_TIC, 8'h08, 8'h08);
        wr(`PTMR_IDX_MODE, 8'h07);
        wr(`PTMR_IDX_MODE, 8'h07);
        rdc(`PTMR_IDX_MODE, 8'h60, 8'h00);
        wr(`PTMR_IDX_TIC, 8'h00);
        wr(`PTMR_IDX_MODE, 8'h0F);
        tick(600);
        rdc(`PTMR_IDX_MODE, 8'h20, 8'h20);
        wr(`PTMR_IDX_MODE, 8'h2F);
        rdc(`PTMR_IDX_MODE, 8'h60, 8'h20);
        wr(`PTMR_IDX_MODE, 8'h0F);
        rdc(`PTMR_IDX_MODE, 8'h60, 8'h00);
        wr(`PTMR_IDX_MODE, 8'h6F);
        rdc(`PTMR_IDX_MODE, 8'h60, 8'h00);
        wr(`PTMR_IDX_MODE, 8'h07);
        poll(`PTMR_IDX_MODE, 8'h08, 8'h00);
        // Event mode counts rising pin edges, start edge included
        wr(`PTMR_IDX_MODE, 8'h03);
        wr(`PTMR_IDX_MODE, 8'h02);
        wr(`PTMR_IDX_PRE, 8'h05);
        wr(`PTMR_IDX_MODE, 8'h0A);
        pin_edge;
        poll(`PTMR_IDX_MODE, 8'h08, 8'h08);
        pin_edge;
        rdc(`PTMR_IDX_PRE, 8'hFF, 8'h03);
        wr(`PTMR_IDX_MODE, 8'h02);
        pin_edge;
        poll(`PTMR_IDX_MODE, 8'h08, 8'h00);
        rdc(`PTMR_IDX_PRE, 8'hFF, 8'h03);
        close_out;
    end
endmodule // testbench
